// ===== core/csa_nv_store.sv
// persistent saturating counters with registered read values
// assumes factory_rst_n is only pulsed for a blank store, never by system reset
`timescale 1ns/100ps
`default_nettype none
module csa_nv_store #(
	parameter int unsigned N = 3,
	parameter int unsigned W = 24
) (
	input  wire logic         clk,
	input  wire logic         factory_rst_n,
	input  wire logic [N-1:0] inc,
	output var  logic [N*W-1:0] value
);
	// one process for all words keeps a single driver on value
	always_ff @(posedge clk or negedge factory_rst_n)
	begin
		if (!factory_rst_n)
			value <= '0;
		else
			for (int i = 0; i < N; i++)
				if (inc[i] && value[i*W +: W] != {W{1'b1}})
					value[i*W +: W] <= value[i*W +: W] + 1'b1;
	end
endmodule
`default_nettype wire

// ===== core/csa_supervisor.sv
// supervisor: modes, hold, key protect, replacement warning, self-diagnosis
// assumes panel pins are asynchronous; value and fault events share pclk
`timescale 1ns/100ps
`default_nettype none
module csa_supervisor #(
	parameter logic [63:0] TENTH_YEAR_CYCLES = csa_pkg::TENTH_YEAR_CYCLES,
	parameter logic [31:0] HALF_FLASH_CYCLES = csa_pkg::HALF_FLASH_CYCLES,
	parameter bit          TWO_OUTPUTS       = 1'b1,
	parameter bit          ANY_MODE          = 1'b1
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               nv_factory_rstn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	input  wire logic [9:0]         panel_pins,
	input  wire logic signed [23:0] present_value,
	input  wire logic               value_valid,
	input  wire logic               ovf_mode_applicable,
	input  wire logic               out1_on_evt,
	input  wire logic               out2_on_evt,
	input  wire logic               cpu_fault_evt,
	input  wire logic               ram_fault_evt,
	input  wire logic               nvm_fault_evt,
	output var  logic               outputs_off,
	output var  logic               outputs_hold,
	output var  logic               display_hold,
	output var  logic               count_halt,
	output var  logic               clear_present,
	output var  logic               init_set_values,
	output var  logic               factory_restore,
	output var  logic               kp_indicator,
	output var  logic               disp_key_ok,
	output var  logic               up_key_ok,
	output var  logic               down_key_ok,
	output var  logic               reset_op,
	output var  logic               replacement_warning,
	output var  logic               display_warning,
	output var  logic               display_flash,
	output var  logic               sub_blank,
	output var  logic               checksum_indication,
	output var  logic [1:0]         fault_code,
	output var  logic [1:0]         mode,
	output var  logic [2:0]         active_cfg
);
	// panel synchroniser: sync1 feeds sync2 only, sync3 is for edges
	logic [9:0]  sync1;
	logic [9:0]  sync2;
	logic [9:0]  sync3;
	logic [2:0]  protect_level;
	logic [2:0]  cfg_pending;
	logic [9:0]  rt_alarm;
	logic [13:0] on1_alarm;
	logic [13:0] on2_alarm;
	logic        underflow;
	logic        overflow;
	logic        cpu_fault;
	logic        ram_fault;
	logic        nvm_fault;
	logic        warn_suppress;
	logic        flash_phase;
	logic        rt_tick;
	logic        flash_tick;
	logic [71:0] nv_val;

	wire [9:0]  rise      = sync2 & ~sync3;
	wire        prot_on   = sync2[csa_pkg::PIN_PROT];
	wire        hold_on   = sync2[csa_pkg::PIN_HOLD];
	wire        in_run    = (mode == csa_pkg::MODE_RUN);
	wire [2:0]  lv        = protect_level;

	// protect gating, level only counts while the switch is on
	wire disp_allow = !prot_on || (lv <= 3'h4);
	wire rst_allow  = !prot_on || lv == 3'h1 || lv == 3'h3 || lv == 3'h6;
	wire ud_allow   = !prot_on || lv == 3'h1 || lv == 3'h2 || lv == 3'h6 || lv == 3'h7;

	wire go_cfg  = in_run && rise[csa_pkg::PIN_KCFG] && !prot_on;
	wire go_fn   = in_run && !rise[csa_pkg::PIN_KCFG] && rise[csa_pkg::PIN_KFN] && !prot_on;
	wire go_run  = !in_run && rise[csa_pkg::PIN_KRUN];
	wire cfg_chg = go_run && (mode == csa_pkg::MODE_CFG) && (cfg_pending != active_cfg);

	wire rst_evt = (in_run && rise[csa_pkg::PIN_KRST] && rst_allow) || rise[csa_pkg::PIN_RSTIN];

	wire [23:0] rt_val  = nv_val[23:0];
	wire [23:0] on1_raw = nv_val[47:24];
	wire [23:0] on2_raw = nv_val[71:48];
	wire [23:0] on1_k   = on1_raw / csa_pkg::ON_SCALE;
	wire [23:0] on2_k   = on2_raw / csa_pkg::ON_SCALE;

	wire rt_hit  = (rt_alarm != 10'h000) && (rt_val >= {14'h0000, rt_alarm});
	wire on1_hit = (on1_alarm != 14'h0000) && (on1_k >= {10'h000, on1_alarm});
	wire on2_hit = TWO_OUTPUTS && (on2_alarm != 14'h0000) && (on2_k >= {10'h000, on2_alarm});
	wire warn_cond = rt_hit || on1_hit || on2_hit;

	wire is_tach   = (active_cfg == csa_pkg::CFG_TACH);
	wire ovf_check = ovf_mode_applicable || is_tach || (active_cfg == csa_pkg::CFG_DUAL);
	wire under_set = value_valid && (present_value < csa_pkg::UNDER_LIMIT);
	wire over_set  = value_valid && ovf_check && (present_value > csa_pkg::OVER_LIMIT);

	wire [2:0] next_cfg_pending = pwdata[2:0];
	wire cfg_code_ok = (next_cfg_pending != 3'h7) &&
		(ANY_MODE || next_cfg_pending == csa_pkg::CFG_PRESET1 || next_cfg_pending == csa_pkg::CFG_TOTAL);

	// register decode
	wire hit_ctrl = (paddr == csa_pkg::OFF_CTRL);
	wire hit_cfg  = (paddr == csa_pkg::OFF_CFG);
	wire hit_rta  = (paddr == csa_pkg::OFF_RT_ALARM);
	wire hit_o1a  = (paddr == csa_pkg::OFF_ON1_ALARM);
	wire hit_o2a  = (paddr == csa_pkg::OFF_ON2_ALARM);
	wire hit_rtm  = (paddr == csa_pkg::OFF_RT_MON);
	wire hit_o1m  = (paddr == csa_pkg::OFF_ON1_MON);
	wire hit_o2m  = (paddr == csa_pkg::OFF_ON2_MON);
	wire hit_st   = (paddr == csa_pkg::OFF_STATUS);
	wire addr_ok  = hit_ctrl | hit_cfg | hit_rta | hit_o1a | hit_o2a | hit_rtm | hit_o1m | hit_o2m | hit_st;

	wire wr_ctrl_ok = hit_ctrl && (pwdata[31:3] == 29'h0) && (pwdata[2:0] != 3'h0);
	wire wr_cfg_ok  = hit_cfg && (pwdata[31:3] == 29'h0) && cfg_code_ok && (mode == csa_pkg::MODE_CFG);
	wire wr_rta_ok  = hit_rta && (pwdata <= {22'h0, csa_pkg::RT_ALARM_MAX});
	wire wr_o1a_ok  = hit_o1a && (pwdata <= {18'h0, csa_pkg::ON_ALARM_MAX});
	wire wr_o2a_ok  = hit_o2a && (pwdata <= {18'h0, csa_pkg::ON_ALARM_MAX});
	wire wr_ok      = wr_ctrl_ok | wr_cfg_ok | wr_rta_ok | wr_o1a_ok | wr_o2a_ok;

	wire setup  = psel && !penable;
	wire commit = psel && penable && pready && pwrite && !pslverr;

	wire [31:0] status_word = {16'h0000, 1'b0, active_cfg, 2'b00, mode,
		warn_suppress, prot_on, nvm_fault, ram_fault, cpu_fault, overflow, underflow, replacement_warning};

	wire [31:0] rdata_mux =
		hit_ctrl ? {29'h0, protect_level} :
		hit_cfg  ? {21'h0, active_cfg, 5'h00, cfg_pending} :
		hit_rta  ? {22'h0, rt_alarm} :
		hit_o1a  ? {18'h0, on1_alarm} :
		hit_o2a  ? {18'h0, on2_alarm} :
		hit_rtm  ? {8'h00, rt_val} :
		hit_o1m  ? {8'h00, on1_k} :
		hit_o2m  ? {8'h00, on2_k} :
		hit_st   ? status_word : 32'h0000_0000;

	wire fault_off = cpu_fault || ram_fault || nvm_fault;
	wire nvm_clear = rst_evt && nvm_fault;

	csa_tick_div #(
		.WIDTH (64),
		.COUNT (TENTH_YEAR_CYCLES)
	) u_rt_div (
		.clk    (pclk),
		.rst_n  (presetn),
		.enable (1'b1),
		.tick   (rt_tick)
	);

	csa_tick_div #(
		.WIDTH (32),
		.COUNT (HALF_FLASH_CYCLES)
	) u_flash_div (
		.clk    (pclk),
		.rst_n  (presetn),
		.enable (1'b1),
		.tick   (flash_tick)
	);

	// powered time and ON counts, untouched by presetn or reset operations
	csa_nv_store #(
		.N (3),
		.W (24)
	) u_nv (
		.clk           (pclk),
		.factory_rst_n (nv_factory_rstn),
		.inc           ({out2_on_evt & TWO_OUTPUTS, out1_on_evt, rt_tick}),
		.value         (nv_val)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
			sync3 <= 10'h000;
		end
		else
		begin
			sync1 <= panel_pins;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// apb slave, zero wait state, error on unmapped or refused access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && (!addr_ok || (pwrite && !wr_ok));
			if (setup && !pwrite)
				prdata <= rdata_mux;
		end
	end

	// settings are persistent: power cycles keep them, a reset operation during a non-volatile fault restores defaults
	always_ff @(posedge pclk or negedge nv_factory_rstn)
	begin
		if (!nv_factory_rstn)
		begin
			protect_level <= csa_pkg::KP_DEFAULT;
			rt_alarm      <= csa_pkg::RT_ALARM_DEFAULT;
			on1_alarm     <= csa_pkg::ON_ALARM_DEFAULT;
			on2_alarm     <= csa_pkg::ON_ALARM_DEFAULT;
		end
		else if (nvm_clear)
		begin
			protect_level <= csa_pkg::KP_DEFAULT;
			rt_alarm      <= csa_pkg::RT_ALARM_DEFAULT;
			on1_alarm     <= csa_pkg::ON_ALARM_DEFAULT;
			on2_alarm     <= csa_pkg::ON_ALARM_DEFAULT;
		end
		else if (commit)
		begin
			if (wr_ctrl_ok)
				protect_level <= pwdata[2:0];
			if (wr_rta_ok)
				rt_alarm <= pwdata[9:0];
			if (wr_o1a_ok)
				on1_alarm <= pwdata[13:0];
			if (wr_o2a_ok)
				on2_alarm <= pwdata[13:0];
		end
	end

	// operating mode and configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode            <= csa_pkg::MODE_RUN;
			active_cfg      <= csa_pkg::CFG_PRESET1;
			cfg_pending     <= csa_pkg::CFG_PRESET1;
			clear_present   <= 1'b0;
			init_set_values <= 1'b0;
		end
		else
		begin
			clear_present   <= go_cfg;
			init_set_values <= cfg_chg || (nvm_clear && active_cfg != csa_pkg::CFG_PRESET1);
			if (nvm_clear)
			begin
				active_cfg  <= csa_pkg::CFG_PRESET1;
				cfg_pending <= csa_pkg::CFG_PRESET1;
			end
			else if (go_cfg)
				cfg_pending <= active_cfg;
			else if (cfg_chg)
				active_cfg <= cfg_pending;
			else if (commit && wr_cfg_ok)
				cfg_pending <= next_cfg_pending;
			unique case (mode)
				csa_pkg::MODE_RUN:
					mode <= go_cfg ? csa_pkg::MODE_CFG : go_fn ? csa_pkg::MODE_FN : csa_pkg::MODE_RUN;
				csa_pkg::MODE_CFG,
				csa_pkg::MODE_FN:
					mode <= go_run ? csa_pkg::MODE_RUN : mode;
				default:
					mode <= csa_pkg::MODE_RUN;
			endcase
		end
	end

	// diagnosis flags; an arriving fault wins over a clearing reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			underflow     <= 1'b0;
			overflow      <= 1'b0;
			cpu_fault     <= 1'b0;
			ram_fault     <= 1'b0;
			nvm_fault     <= 1'b0;
			warn_suppress <= 1'b0;
		end
		else
		begin
			underflow     <= under_set || (underflow && !rst_evt);
			overflow      <= over_set || (overflow && !(rst_evt && !is_tach));
			cpu_fault     <= cpu_fault_evt || (cpu_fault && !rst_evt);
			ram_fault     <= ram_fault_evt || ram_fault;
			nvm_fault     <= nvm_fault_evt || (nvm_fault && !rst_evt);
			warn_suppress <= warn_suppress || rst_evt;
		end
	end

	// panel and output control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			outputs_off         <= 1'b1;
			outputs_hold        <= 1'b0;
			display_hold        <= 1'b0;
			count_halt          <= 1'b0;
			factory_restore     <= 1'b0;
			kp_indicator        <= 1'b0;
			disp_key_ok         <= 1'b0;
			up_key_ok           <= 1'b0;
			down_key_ok         <= 1'b0;
			reset_op            <= 1'b0;
			replacement_warning <= 1'b0;
			display_warning     <= 1'b0;
			display_flash       <= 1'b0;
			sub_blank           <= 1'b0;
			checksum_indication <= 1'b0;
			fault_code          <= 2'b00;
			flash_phase         <= 1'b0;
		end
		else
		begin
			outputs_off  <= (mode == csa_pkg::MODE_CFG) || fault_off;
			outputs_hold <= hold_on && in_run;
			display_hold <= hold_on && in_run;
			count_halt   <= (mode == csa_pkg::MODE_CFG);
			factory_restore <= nvm_clear;
			kp_indicator <= prot_on;
			disp_key_ok  <= in_run && rise[csa_pkg::PIN_KDISP] && disp_allow;
			up_key_ok    <= rise[csa_pkg::PIN_KUP] && ud_allow;
			down_key_ok  <= rise[csa_pkg::PIN_KDOWN] && ud_allow;
			reset_op     <= rst_evt;
			replacement_warning <= warn_cond && !warn_suppress && !rst_evt;
			if (flash_tick)
				flash_phase <= !flash_phase;
			display_warning <= replacement_warning && flash_phase;
			display_flash   <= (underflow || overflow) && flash_phase;
			sub_blank       <= cpu_fault || ram_fault;
			checksum_indication <= nvm_fault;
			fault_code <= cpu_fault ? 2'b01 : (ram_fault || nvm_fault) ? 2'b10 : 2'b00;
		end
	end
endmodule
`default_nettype wire

// ===== core/csa_tick_div.sv
// one-cycle tick every COUNT enabled cycles
// assumes a single clock; used for slow rates without extra clocks
`timescale 1ns/100ps
`default_nettype none
module csa_tick_div #(
	parameter int unsigned       WIDTH = 32,
	parameter logic [WIDTH-1:0]  COUNT = 1000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	output var  logic tick
);
	logic [WIDTH-1:0] cnt;
	wire              wrap = (cnt == COUNT - 1'b1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt  <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= enable & wrap;
			if (enable)
				cnt <= wrap ? '0 : cnt + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== pkg/csa_pkg.sv
// constants, register map and state codes for the counter supervisor
// assumes one 125 MHz clock and an APB slave with 32-bit data
`default_nettype none
package csa_pkg;
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_CFG       = 8'h04;
	localparam logic [7:0] OFF_RT_ALARM  = 8'h08;
	localparam logic [7:0] OFF_ON1_ALARM = 8'h0c;
	localparam logic [7:0] OFF_ON2_ALARM = 8'h10;
	localparam logic [7:0] OFF_RT_MON    = 8'h14;
	localparam logic [7:0] OFF_ON1_MON   = 8'h18;
	localparam logic [7:0] OFF_ON2_MON   = 8'h1c;
	localparam logic [7:0] OFF_STATUS    = 8'h20;

	localparam logic [2:0]  KP_DEFAULT       = 3'h1;
	localparam logic [9:0]  RT_ALARM_DEFAULT = 10'h064;
	localparam logic [9:0]  RT_ALARM_MAX     = 10'h3e7;
	localparam logic [13:0] ON_ALARM_DEFAULT = 14'h0064;
	localparam logic [13:0] ON_ALARM_MAX     = 14'h270f;
	localparam logic [23:0] ON_SCALE         = 24'h0003e8;
	localparam logic signed [23:0] UNDER_LIMIT = 24'shfe7961;
	localparam logic signed [23:0] OVER_LIMIT  = 24'sh0f423f;

	localparam int unsigned ST_WARN    = 0;
	localparam int unsigned ST_UNDER   = 1;
	localparam int unsigned ST_OVER    = 2;
	localparam int unsigned ST_CPU     = 3;
	localparam int unsigned ST_RAM     = 4;
	localparam int unsigned ST_NVM     = 5;
	localparam int unsigned ST_KP_LIT  = 6;
	localparam int unsigned ST_SUPPR   = 7;
	localparam int unsigned ST_MODE    = 8;
	localparam int unsigned ST_ACT_CFG = 12;
	localparam int unsigned CFG_ACTIVE = 8;

	localparam int unsigned PIN_HOLD   = 0;
	localparam int unsigned PIN_RSTIN  = 1;
	localparam int unsigned PIN_PROT   = 2;
	localparam int unsigned PIN_KRST   = 3;
	localparam int unsigned PIN_KDISP  = 4;
	localparam int unsigned PIN_KUP    = 5;
	localparam int unsigned PIN_KDOWN  = 6;
	localparam int unsigned PIN_KCFG   = 7;
	localparam int unsigned PIN_KFN    = 8;
	localparam int unsigned PIN_KRUN   = 9;
	localparam int unsigned PIN_COUNT  = 10;

	localparam longint unsigned CLK_HZ          = 125000000;
	localparam longint unsigned FLASH_PERIOD_MS = 1000;
	localparam longint unsigned TENTH_YEAR_S    = 3155760;
	localparam logic [31:0] HALF_FLASH_CYCLES = 32'(CLK_HZ / 1000 * FLASH_PERIOD_MS / 2);
	localparam logic [63:0] TENTH_YEAR_CYCLES = 64'(TENTH_YEAR_S * CLK_HZ);

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_CFG = 2'b01,
		MODE_FN  = 2'b10
	} csa_mode_e;

	typedef enum logic [2:0] {
		CFG_PRESET1 = 3'b000,
		CFG_PRESET2 = 3'b001,
		CFG_TOTAL   = 3'b010,
		CFG_BATCH   = 3'b011,
		CFG_DUAL    = 3'b100,
		CFG_TWIN    = 3'b101,
		CFG_TACH    = 3'b110
	} csa_cfg_e;
endpackage
`default_nettype wire

// ===== tb/csa_panel_model.sv
// front-panel model: keys, protect switch, hold and reset input levels
// assumes the caller is synchronous to clk; levels stand long enough to sync
`timescale 1ns/100ps
`default_nettype none
module csa_panel_model (
	input  wire logic       clk,
	output var  logic [9:0] pins
);
	initial pins = 10'h000;
	task automatic set(input int i, input logic v);
		@(posedge clk);
		pins[i] <= v;
		repeat (6) @(posedge clk);
	endtask
	task automatic press(input int i);
		set(i, 1'b1);
		set(i, 1'b0);
	endtask
endmodule
`default_nettype wire

// ===== tb/csa_supervisor_properties.sv
// port checker for the counter supervisor, bound to its top module
// assumes one pclk domain with presetn as asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module csa_supervisor_properties (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [9:0] panel_pins,
	input wire logic       outputs_off,
	input wire logic       outputs_hold,
	input wire logic       display_hold,
	input wire logic       count_halt,
	input wire logic       clear_present,
	input wire logic       kp_indicator,
	input wire logic       replacement_warning,
	input wire logic       display_warning,
	input wire logic       checksum_indication,
	input wire logic       sub_blank,
	input wire logic [1:0] fault_code,
	input wire logic [1:0] mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	cfg_off_a: assert property ((mode == 2'h1) [*2] |-> outputs_off && count_halt)
		else $error("config mode left outputs on");
	cfg_clear_a: assert property (clear_present |-> mode == 2'h1 && $past(mode) == 2'h0)
		else $error("clear pulse without config entry");
	kp_on_a: assert property ((panel_pins[2]) [*5] |-> kp_indicator)
		else $error("protect indicator dark");
	kp_off_a: assert property ((!panel_pins[2]) [*5] |-> !kp_indicator)
		else $error("protect indicator lit");
	mode_lock_a: assert property ((panel_pins[2] && mode == 2'h0) [*5] |=> mode == 2'h0)
		else $error("mode changed under protect");
	hold_freeze_a: assert property ((panel_pins[0] && mode == 2'h0) [*5] |-> outputs_hold && display_hold)
		else $error("hold not applied");
	warn_flash_a: assert property (display_warning |-> $past(replacement_warning))
		else $error("warning display without warning");
	fault_off_a: assert property ((sub_blank || checksum_indication) [*2] |-> outputs_off)
		else $error("outputs on during fault");
	cpu_blank_a: assert property ((fault_code == 2'h1) [*2] |-> sub_blank)
		else $error("sub display lit in processor fault");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	cover property (mode == 2'h1);
	cover property (replacement_warning);
	cover property (checksum_indication);
endmodule
bind csa_supervisor csa_supervisor_properties u_props (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .panel_pins, .outputs_off,
	.outputs_hold, .display_hold, .count_halt, .clear_present, .kp_indicator,
	.replacement_warning, .display_warning, .checksum_indication, .sub_blank, .fault_code, .mode
);
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the counter supervisor over APB and panel pins
// assumes short tenth-year and flash counts set by parameter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic               pclk, presetn, nv_factory_rstn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, r;
	logic signed [23:0] present_value;
	logic               value_valid, ovf_mode_applicable, out1_on_evt, out2_on_evt;
	logic               cpu_fault_evt, ram_fault_evt, nvm_fault_evt, outputs_off, outputs_hold;
	logic               display_hold, count_halt, clear_present, init_set_values, factory_restore;
	logic               kp_indicator, disp_key_ok, up_key_ok, down_key_ok, reset_op, replacement_warning;
	logic               display_warning, display_flash, sub_blank, checksum_indication;
	logic [1:0]         fault_code, mode;
	logic [2:0]         active_cfg;
	logic [9:0]         panel_pins;
	int                 failures, compares, n_disp, n_up, n_dn, n_rst, n_init, n_fr, n_dw, n_fl, a, b, c, dn;
	csa_panel_model panel (.clk(pclk), .pins(panel_pins));
	csa_supervisor #(.TENTH_YEAR_CYCLES(64'd20), .HALF_FLASH_CYCLES(32'd4)) dut (
		.pclk, .presetn, .nv_factory_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .panel_pins, .present_value, .value_valid, .ovf_mode_applicable,
		.out1_on_evt, .out2_on_evt, .cpu_fault_evt, .ram_fault_evt, .nvm_fault_evt, .outputs_off,
		.outputs_hold, .display_hold, .count_halt, .clear_present, .init_set_values, .factory_restore,
		.kp_indicator, .disp_key_ok, .up_key_ok, .down_key_ok, .reset_op, .replacement_warning,
		.display_warning, .display_flash, .sub_blank, .checksum_indication, .fault_code, .mode, .active_cfg
	);
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (disp_key_ok === 1'b1) n_disp++;
		if (up_key_ok === 1'b1) n_up++;
		if (down_key_ok === 1'b1) n_dn++;
		if (reset_op === 1'b1) n_rst++;
		if (init_set_values === 1'b1) n_init++;
		if (factory_restore === 1'b1) n_fr++;
		if (display_warning === 1'b1) n_dw++;
		if (display_flash === 1'b1) n_fl++;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x)
		begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(r, x);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic x);
		apb(1'b1, ad, d);
		chk({31'h0, e}, {31'h0, x});
	endtask
	task automatic val(input logic signed [23:0] v, input logic [1:0] x);
		@(posedge pclk);
		present_value <= v;
		value_valid <= 1'b1;
		@(posedge pclk) value_valid <= 1'b0;
		apb(1'b0, csa_pkg::OFF_STATUS, 32'h0);
		chk(r[2:1], x);
	endtask
	task automatic pwr;
		@(posedge pclk) presetn <= 1'b0;
		wt(3);
		presetn <= 1'b1;
		wt(6);
	endtask
	task stop_test;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		wt(40000);
		failures++;
		stop_test();
	end
	initial
	begin
		{presetn, nv_factory_rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		{present_value, value_valid, ovf_mode_applicable, out1_on_evt, out2_on_evt} = '0;
		{cpu_fault_evt, ram_fault_evt, nvm_fault_evt} = '0;
		wt(10);
		presetn <= 1'b1;
		nv_factory_rstn <= 1'b1;
		rd(csa_pkg::OFF_CTRL, 32'h1);
		rd(csa_pkg::OFF_RT_ALARM, 32'h64);
		rd(csa_pkg::OFF_ON2_ALARM, 32'h64);
		wr(csa_pkg::OFF_RT_ALARM, 32'h3e8, 1'b1);
		wr(csa_pkg::OFF_ON1_ALARM, 32'h2710, 1'b1);
		wr(csa_pkg::OFF_ON1_MON, 32'h0, 1'b1);
		wr(8'h24, 32'h0, 1'b1);
		wr(csa_pkg::OFF_RT_ALARM, 32'h0, 1'b0);
		wr(csa_pkg::OFF_ON1_ALARM, 32'h1, 1'b0);
		wr(csa_pkg::OFF_CFG, 32'h2, 1'b1);
		panel.press(csa_pkg::PIN_KCFG);
		chk(mode, 2'h1);
		chk({outputs_off, count_halt}, 2'h3);
		wr(csa_pkg::OFF_CFG, 32'h2, 1'b0);
		rd(csa_pkg::OFF_CFG, 32'h2);
		a = n_init;
		panel.press(csa_pkg::PIN_KRUN);
		chk({mode, active_cfg}, 5'h02);
		panel.press(csa_pkg::PIN_KCFG);
		panel.press(csa_pkg::PIN_KRUN);
		chk(32'(n_init - a), 32'h1);
		for (int i = 0; i < 999; i++)
		begin
			@(posedge pclk) out1_on_evt <= 1'b1;
			@(posedge pclk) out1_on_evt <= 1'b0;
		end
		wt(4);
		chk(replacement_warning, 1'b0);
		@(posedge pclk) out1_on_evt <= 1'b1;
		@(posedge pclk) out1_on_evt <= 1'b0;
		wt(4);
		chk(replacement_warning, 1'b1);
		rd(csa_pkg::OFF_ON1_MON, 32'h1);
		a = n_dw;
		wt(20);
		chk(32'(n_dw - a > 0 && n_dw - a < 20), 32'h1);
		chk(outputs_off, 1'b0);
		panel.press(csa_pkg::PIN_KRST);
		chk(replacement_warning, 1'b0);
		rd(csa_pkg::OFF_ON1_MON, 32'h1);
		pwr();
		chk(replacement_warning, 1'b1);
		rd(csa_pkg::OFF_ON1_MON, 32'h1);
		wr(csa_pkg::OFF_ON1_ALARM, 32'h0, 1'b0);
		wr(csa_pkg::OFF_ON2_ALARM, 32'h1, 1'b0);
		wt(2);
		chk(replacement_warning, 1'b0);
		for (int i = 0; i < 1000; i++)
		begin
			@(posedge pclk) out2_on_evt <= 1'b1;
			@(posedge pclk) out2_on_evt <= 1'b0;
		end
		wt(4);
		chk(replacement_warning, 1'b1);
		apb(1'b0, csa_pkg::OFF_RT_MON, 32'h0);
		a = int'(r);
		wt(37);
		apb(1'b0, csa_pkg::OFF_RT_MON, 32'h0);
		chk(r - 32'(a), 32'h2);
		panel.set(csa_pkg::PIN_PROT, 1'b1);
		chk(kp_indicator, 1'b1);
		panel.press(csa_pkg::PIN_KCFG);
		panel.press(csa_pkg::PIN_KFN);
		chk(mode, 2'h0);
		wr(csa_pkg::OFF_CTRL, 32'h0, 1'b1);
		for (int lv = 1; lv <= 7; lv++)
		begin
			wr(csa_pkg::OFF_CTRL, 32'(lv), 1'b0);
			a = n_disp;
			b = n_rst;
			c = n_up;
			dn = n_dn;
			panel.press(csa_pkg::PIN_KDISP);
			panel.press(csa_pkg::PIN_KRST);
			panel.press(csa_pkg::PIN_KUP);
			panel.press(csa_pkg::PIN_KDOWN);
			chk(32'(n_disp - a), 32'(lv <= 4));
			chk(32'(n_rst - b), 32'(lv == 1 || lv == 3 || lv == 6));
			chk(32'(n_up - c), 32'(lv <= 2 || lv >= 6));
			chk(32'(n_dn - dn), 32'(lv <= 2 || lv >= 6));
		end
		panel.set(csa_pkg::PIN_PROT, 1'b0);
		chk(kp_indicator, 1'b0);
		panel.set(csa_pkg::PIN_HOLD, 1'b1);
		chk({outputs_hold, display_hold}, 2'h3);
		panel.set(csa_pkg::PIN_HOLD, 1'b0);
		chk({outputs_hold, display_hold}, 2'h0);
		val(-24'sd99999, 2'h0);
		val(-24'sd100000, 2'h1);
		a = n_fl;
		wt(20);
		chk(32'(n_fl - a > 0 && n_fl - a < 20), 32'h1);
		panel.press(csa_pkg::PIN_RSTIN);
		val(24'sd999999, 2'h0);
		ovf_mode_applicable <= 1'b1;
		val(24'sd1000000, 2'h2);
		panel.press(csa_pkg::PIN_KRST);
		val(24'sd0, 2'h0);
		ovf_mode_applicable <= 1'b0;
		panel.press(csa_pkg::PIN_KCFG);
		wr(csa_pkg::OFF_CFG, 32'h6, 1'b0);
		panel.press(csa_pkg::PIN_KRUN);
		val(24'sd1000000, 2'h2);
		panel.press(csa_pkg::PIN_KRST);
		val(24'sd0, 2'h2);
		pwr();
		@(posedge pclk) cpu_fault_evt <= 1'b1;
		@(posedge pclk) cpu_fault_evt <= 1'b0;
		wt(4);
		chk({outputs_off, sub_blank, fault_code}, 4'hd);
		panel.press(csa_pkg::PIN_KRST);
		chk({outputs_off, sub_blank}, 2'h0);
		@(posedge pclk) ram_fault_evt <= 1'b1;
		@(posedge pclk) ram_fault_evt <= 1'b0;
		panel.press(csa_pkg::PIN_KRST);
		chk({outputs_off, fault_code}, 3'h6);
		pwr();
		chk(outputs_off, 1'b0);
		@(posedge pclk) nvm_fault_evt <= 1'b1;
		@(posedge pclk) nvm_fault_evt <= 1'b0;
		wt(4);
		chk({outputs_off, checksum_indication}, 2'h3);
		a = n_fr;
		panel.press(csa_pkg::PIN_KRST);
		chk(32'(n_fr - a), 32'h1);
		rd(csa_pkg::OFF_CTRL, 32'h1);
		rd(csa_pkg::OFF_RT_ALARM, 32'h64);
		stop_test();
	end
endmodule
`default_nettype wire
